// file: hw/mripi_core.v
// Reset recognition, idle / power-down control and interrupt entry.
// Assumes clk is the oscillator, a single AHB-Lite master and a core
// that acknowledges the vector it takes with a one-cycle pulse.
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "mripi_defs.vh"

// Behaviour
// - Six interrupt sources feed enable, priority logic
// - Timer-2 request is overflow OR trigger flag
// - Vectoring leaves both timer-2 flags untouched
// - Software writes set or cancel any flag
// - Fixed vector addresses 0003H through 002BH
// - Equal level served external-0 first, timer-2 last
// - Reset pin high 24 oscillator periods resets
// - Oscillator divided by two before internal use
// - Idle halts the core, peripherals keep running
// - Idle keeps core state, RAM, registers
// - Enabled interrupt ends idle, enters its routine
// - Hardware reset ends idle like power-on
// - Power-down stops oscillator after requesting write
// - Only hardware reset leaves power-down
// - Low-power requests live in power control register
// - Idle: strobes high, port 0 floats externally
// - Power-down: strobes low, port 2 keeps data
// - Warn whenever external interrupts armed, in any mode
// - Baud generator rollover sets no overflow flag
// - Enabled trigger falling edge sets external flag
module mripi_core (
  // Clock and power-on reset
  input wire clk,
  input wire rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  // Reset pin and core reset
  input wire reset_pin,
  output reg core_reset,
  // Interrupt events from peripherals, one-cycle pulses, and the level timer-2 trigger pin
  input wire ext_ext_interrupt_pin_a_event,
  input wire timer0_overflow_event,
  input wire ext_ext_interrupt_pin_b_event,
  input wire timer1_overflow_event,
  input wire serial_receive_event,
  input wire serial_transmit_event,
  input wire timer2_rollover_event,
  input wire timer2_trigger_pin,
  // Core interface
  input wire irq_ack,
  output wire irq_request,
  output reg [15:0] irq_vector,
  output wire cpu_halt,
  output wire state_phase,
  output wire osc_stop,
  output wire peripheral_run,
  // Pin control in low-power modes
  input wire ext_program_mem,
  input wire core_address_latch,
  input wire core_program_store_strobe,
  output wire address_latch_strobe,
  output wire program_store_strobe,
  output wire port0_float,
  output wire port2_drive_address
);

  // ==========================================================
  // Bus slave
  reg wr_pending_reg;
  reg [7:0] wr_addr_reg;
  wire addr_phase;
  wire [7:0] bus_addr;
  wire wr_strobe;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & hready & htrans[1];
  assign bus_addr = {haddr[7:2], 2'b00};
  // Zero wait states, so a write lands one cycle after its address
  assign wr_strobe = wr_pending_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pending_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pending_reg <= addr_phase & hwrite;
      wr_addr_reg <= bus_addr;
    end
  end

  // ==========================================================
  // Reset pin: three-stage synchroniser and hold counter
  reg [2:0] rpin_sync_reg;
  reg rpin_level_reg;
  reg [4:0] rhold_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rpin_sync_reg <= 3'h0;
      rpin_level_reg <= 1'b0;
      rhold_reg <= 5'h00;
      core_reset <= 1'b1;
    end else begin
      rpin_sync_reg <= {rpin_sync_reg[1:0], reset_pin};
      if (rpin_sync_reg[1] == rpin_sync_reg[2]) begin
        rpin_level_reg <= rpin_sync_reg[2];
      end
      // Counts on clk and is not gated by power-down, so the pin is still timed while the oscillator is off
      if (!rpin_level_reg) begin
        rhold_reg <= 5'h00;
        core_reset <= 1'b0;
      end else if (rhold_reg == `MRIPI_RESET_CYCLES - 5'h01) begin
        core_reset <= 1'b1;
      end else begin
        rhold_reg <= rhold_reg + 5'h01;
      end
    end
  end

  wire any_reset;
  assign any_reset = core_reset;

  // ==========================================================
  // Timer-2 trigger pin synchroniser
  reg [2:0] trig_sync_reg;
  reg trig_level_reg;
  reg trig_prev_reg;
  wire trig_fall;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_sync_reg <= 3'h7;
      trig_level_reg <= 1'b1;
      trig_prev_reg <= 1'b1;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], timer2_trigger_pin};
      if (trig_sync_reg[1] == trig_sync_reg[2]) begin
        trig_level_reg <= trig_sync_reg[2];
      end
      trig_prev_reg <= trig_level_reg;
    end
  end

  assign trig_fall = trig_prev_reg & ~trig_level_reg;

  // ==========================================================
  // Registers
  reg [1:0] power_control_register;
  reg [1:0] power_control_next;
  reg [7:0] flags_reg;
  reg [7:0] flags_next;
  reg [7:0] enable_reg;
  reg [5:0] priority_reg;
  reg [1:0] t2_ctrl_reg;
  wire idle_mode;
  wire pdown_mode;
  wire timer2_baud_mode;
  wire timer2_trigger_enable;

  assign idle_mode = power_control_register[`MRIPI_PWR_IDLE_BIT];
  assign pdown_mode = power_control_register[`MRIPI_PWR_DOWN_BIT];
  assign timer2_baud_mode = t2_ctrl_reg[`MRIPI_T2_BAUD_BIT];
  assign timer2_trigger_enable = t2_ctrl_reg[`MRIPI_T2_TRIG_EN_BIT];

  // ==========================================================
  // Interrupt requests and selection
  wire [5:0] src_req;
  wire [5:0] src_active;
  wire global_en;
  reg sel_valid;
  reg [2:0] sel_idx;
  reg sel_high;
  integer i;

  assign global_en = enable_reg[`MRIPI_EN_GLOBAL_BIT];
  assign src_req[0] = flags_reg[`MRIPI_FLG_EXT0];
  assign src_req[1] = flags_reg[`MRIPI_FLG_TMR0];
  assign src_req[2] = flags_reg[`MRIPI_FLG_EXT1];
  assign src_req[3] = flags_reg[`MRIPI_FLG_TMR1];
  assign src_req[4] = flags_reg[`MRIPI_FLG_SRX] | flags_reg[`MRIPI_FLG_STX];
  assign src_req[5] = flags_reg[`MRIPI_FLG_T2OVF] | flags_reg[`MRIPI_FLG_T2EXT];
  assign src_active = src_req & enable_reg[5:0] & {6{global_en}};

  // Scan from lowest to highest index; a later hit only wins when it
  // is of a strictly higher level, so order within a level holds
  always @* begin
    sel_valid = 1'b0;
    sel_idx = 3'h0;
    sel_high = 1'b0;
    for (i = 0; i < `MRIPI_NUM_SOURCES; i = i + 1) begin
      if (src_active[i] && (!sel_valid || (priority_reg[i] && !sel_high))) begin
        sel_valid = 1'b1;
        sel_idx = i[2:0];
        sel_high = priority_reg[i];
      end
    end
  end

  // Power-down must not be woken, so no request leaves the block then
  assign irq_request = sel_valid & ~pdown_mode & ~any_reset;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_vector <= `MRIPI_VEC_EXT0;
    end else begin
      case (sel_idx)
        3'h0: irq_vector <= `MRIPI_VEC_EXT0;
        3'h1: irq_vector <= `MRIPI_VEC_TMR0;
        3'h2: irq_vector <= `MRIPI_VEC_EXT1;
        3'h3: irq_vector <= `MRIPI_VEC_TMR1;
        3'h4: irq_vector <= `MRIPI_VEC_SERIAL;
        3'h5: irq_vector <= `MRIPI_VEC_TMR2;
        default: irq_vector <= `MRIPI_VEC_EXT0;
      endcase
    end
  end

  // ==========================================================
  // Flag update: software write, vector clear, then hardware set wins
  reg [2:0] ack_idx_reg;
  wire sw_flag_wr;
  wire [7:0] hw_set;

  assign sw_flag_wr = wr_strobe && (wr_addr_reg == `MRIPI_ADDR_FLAGS);
  assign hw_set[`MRIPI_FLG_EXT0] = ext_ext_interrupt_pin_a_event;
  assign hw_set[`MRIPI_FLG_TMR0] = timer0_overflow_event;
  assign hw_set[`MRIPI_FLG_EXT1] = ext_ext_interrupt_pin_b_event;
  assign hw_set[`MRIPI_FLG_TMR1] = timer1_overflow_event;
  assign hw_set[`MRIPI_FLG_SRX] = serial_receive_event;
  assign hw_set[`MRIPI_FLG_STX] = serial_transmit_event;
  assign hw_set[`MRIPI_FLG_T2OVF] = timer2_rollover_event & ~timer2_baud_mode;
  assign hw_set[`MRIPI_FLG_T2EXT] = trig_fall & timer2_trigger_enable;

  always @* begin
    flags_next = flags_reg;
    if (sw_flag_wr) begin
      flags_next = hwdata[7:0];
    end
    // Only the four edge-type sources self-clear on vectoring
    if (irq_ack) begin
      case (ack_idx_reg)
        3'h0: flags_next[`MRIPI_FLG_EXT0] = 1'b0;
        3'h1: flags_next[`MRIPI_FLG_TMR0] = 1'b0;
        3'h2: flags_next[`MRIPI_FLG_EXT1] = 1'b0;
        3'h3: flags_next[`MRIPI_FLG_TMR1] = 1'b0;
        default: flags_next = flags_next;
      endcase
    end
    flags_next = flags_next | hw_set;
  end

  // ==========================================================
  // Power control: requests, wake and reset
  wire sw_pwr_wr;

  assign sw_pwr_wr = wr_strobe && (wr_addr_reg == `MRIPI_ADDR_POWER_CTRL);

  always @* begin
    power_control_next = power_control_register;
    if (sw_pwr_wr) begin
      // Writes only set requests; software cannot leave power-down
      power_control_next = power_control_register | hwdata[1:0];
    end
    if (idle_mode && sel_valid) begin
      power_control_next[`MRIPI_PWR_IDLE_BIT] = 1'b0;
    end
    if (pdown_mode) begin
      power_control_next[`MRIPI_PWR_DOWN_BIT] = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      power_control_register <= `MRIPI_PWR_RESET;
      flags_reg <= `MRIPI_FLG_RESET;
      enable_reg <= `MRIPI_EN_RESET;
      priority_reg <= `MRIPI_PRI_RESET;
      t2_ctrl_reg <= `MRIPI_T2_RESET;
      ack_idx_reg <= 3'h0;
    end else if (any_reset) begin
      power_control_register <= `MRIPI_PWR_RESET;
      flags_reg <= `MRIPI_FLG_RESET;
      enable_reg <= `MRIPI_EN_RESET;
      priority_reg <= `MRIPI_PRI_RESET;
      t2_ctrl_reg <= `MRIPI_T2_RESET;
      ack_idx_reg <= 3'h0;
    end else begin
      power_control_register <= power_control_next;
      flags_reg <= flags_next;
      ack_idx_reg <= sel_idx;
      if (wr_strobe && wr_addr_reg == `MRIPI_ADDR_ENABLE) begin
        enable_reg <= hwdata[7:0];
      end
      if (wr_strobe && wr_addr_reg == `MRIPI_ADDR_PRIORITY) begin
        priority_reg <= hwdata[5:0];
      end
      if (wr_strobe && wr_addr_reg == `MRIPI_ADDR_T2_CTRL) begin
        t2_ctrl_reg <= hwdata[1:0];
      end
    end
  end

  // ==========================================================
  // Divide-by-two state clock, frozen while the oscillator is off
  reg phase_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 1'b0;
    end else if (!pdown_mode) begin
      phase_reg <= ~phase_reg;
    end
  end

  assign state_phase = phase_reg;
  assign osc_stop = pdown_mode;
  // Core stops; its registers hold because it sees no new cycles
  assign cpu_halt = idle_mode | pdown_mode | any_reset;
  assign peripheral_run = ~pdown_mode;

  // ==========================================================
  // Pin states in low-power modes
  assign address_latch_strobe = pdown_mode ? 1'b0 :
    (idle_mode ? 1'b1 : core_address_latch);
  assign program_store_strobe = pdown_mode ? 1'b0 :
    (idle_mode ? 1'b1 : core_program_store_strobe);
  assign port0_float = (idle_mode | pdown_mode) & ext_program_mem;
  assign port2_drive_address = ext_program_mem & ~pdown_mode;

  // ==========================================================
  // Read data, captured in the address phase
  wire ext_armed_warn;
  reg [31:0] rd_value;

  // Set while the global enable and either external interrupt enable are on, in any mode
  assign ext_armed_warn = global_en & (enable_reg[0] | enable_reg[2]);

  always @* begin
    case (bus_addr)
      `MRIPI_ADDR_POWER_CTRL: rd_value = {30'h0, power_control_register};
      `MRIPI_ADDR_FLAGS: rd_value = {24'h0, flags_reg};
      `MRIPI_ADDR_ENABLE: rd_value = {24'h0, enable_reg};
      `MRIPI_ADDR_PRIORITY: rd_value = {26'h0, priority_reg};
      `MRIPI_ADDR_T2_CTRL: rd_value = {30'h0, t2_ctrl_reg};
      `MRIPI_ADDR_STATUS: rd_value = {16'h0, irq_vector[7:0], ext_armed_warn,
        sel_idx, sel_valid, 1'b0, pdown_mode, idle_mode};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_value;
    end
  end

endmodule // mripi_core
`default_nettype wire

// file: hw/mripi_defs.vh
// Constants for the reset, low-power and interrupt-entry block.
// Assumes a 50 MHz clk that is also the oscillator period.
`ifndef MRIPI_DEFS_VH
`define MRIPI_DEFS_VH

// ==========================================================
// Register byte addresses
`define MRIPI_ADDR_POWER_CTRL 8'h00
`define MRIPI_ADDR_FLAGS 8'h04
`define MRIPI_ADDR_ENABLE 8'h08
`define MRIPI_ADDR_PRIORITY 8'h0C
`define MRIPI_ADDR_T2_CTRL 8'h10
`define MRIPI_ADDR_STATUS 8'h14

// ==========================================================
// Power control fields
`define MRIPI_PWR_IDLE_BIT 0
`define MRIPI_PWR_DOWN_BIT 1
`define MRIPI_PWR_RESET 2'h0

// ==========================================================
// Flag register fields
`define MRIPI_FLG_EXT0 0
`define MRIPI_FLG_TMR0 1
`define MRIPI_FLG_EXT1 2
`define MRIPI_FLG_TMR1 3
`define MRIPI_FLG_SRX 4
`define MRIPI_FLG_STX 5
`define MRIPI_FLG_T2OVF 6
`define MRIPI_FLG_T2EXT 7
`define MRIPI_FLG_RESET 8'h00

// ==========================================================
// Enable, priority and timer-2 control fields
`define MRIPI_EN_GLOBAL_BIT 7
`define MRIPI_EN_RESET 8'h00
`define MRIPI_PRI_RESET 6'h00
`define MRIPI_T2_BAUD_BIT 0
`define MRIPI_T2_TRIG_EN_BIT 1
`define MRIPI_T2_RESET 2'h0

// ==========================================================
// Interrupt sources and vectors
`define MRIPI_NUM_SOURCES 6
`define MRIPI_VEC_EXT0 16'h0003
`define MRIPI_VEC_TMR0 16'h000B
`define MRIPI_VEC_EXT1 16'h0013
`define MRIPI_VEC_TMR1 16'h001B
`define MRIPI_VEC_SERIAL 16'h0023
`define MRIPI_VEC_TMR2 16'h002B

// ==========================================================
// Reset timing
`define MRIPI_OSC_PERIOD_NS 20
`define MRIPI_RESET_OSC_PERIODS 24
`define MRIPI_RESET_CYCLES 5'h18

`endif

// file: verification/mcu_reset_idle_powerdown_irq_test.sv
// Self-checking bench for the reset, low-power and interrupt block.
// Assumes one AHB-Lite slave and the partner model on the far side.
`timescale 1ns/10ps
`default_nettype none
module mcu_reset_idle_powerdown_irq_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic ext_mem = 1'b0;
  logic core_ale = 1'b0;
  logic core_pss = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] rd;
  wire hreadyout, hresp, reset_pin, core_reset, irq_request, irq_ack, cpu_halt;
  wire state_phase, osc_stop, ale, pss, p0f, p2a, t2pin, prun;
  wire [31:0] hrdata;
  wire [15:0] irq_vector;
  wire [6:0] ev;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  initial forever #10 clk = ~clk;
  // ==========
  // Design and far side
  mripi_core u_mripi_core (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .reset_pin(reset_pin),
    .core_reset(core_reset), .ext_ext_interrupt_pin_a_event(ev[0]), .timer0_overflow_event(ev[1]),
    .ext_ext_interrupt_pin_b_event(ev[2]), .timer1_overflow_event(ev[3]), .serial_receive_event(ev[4]),
    .serial_transmit_event(ev[5]), .timer2_rollover_event(ev[6]),
    .timer2_trigger_pin(t2pin), .irq_ack(irq_ack), .irq_request(irq_request),
    .irq_vector(irq_vector), .cpu_halt(cpu_halt), .state_phase(state_phase),
    .osc_stop(osc_stop), .peripheral_run(prun), .ext_program_mem(ext_mem),
    .core_address_latch(core_ale), .core_program_store_strobe(core_pss),
    .address_latch_strobe(ale), .program_store_strobe(pss), .port0_float(p0f),
    .port2_drive_address(p2a));
  mripi_partner u_mripi_partner (.clk(clk), .reset_pin(reset_pin), .events(ev),
    .timer2_trigger_pin(t2pin), .irq_ack(irq_ack));
  // ==========
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
    chk("hresp okay", hresp, 1'b0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_regs;
    bus(0, 8'h00, 0);
    chk("power ctrl", rd, 32'h0);
    bus(0, 8'h04, 0);
    chk("flags", rd, 32'h0);
    bus(1, 8'h20, 32'hFF);
    bus(0, 8'h20, 0);
    chk("unmapped", rd, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_events;
    for (int i = 0; i < 7; i++) begin
      u_mripi_partner.pulse(i);
      bus(0, 8'h04, 0);
      chk("event flag", rd, 32'h1 << i);
      bus(1, 8'h04, 0);
    end
    bus(1, 8'h10, 32'h3);
    u_mripi_partner.pulse(6);
    bus(0, 8'h04, 0);
    chk("baud rollover", rd, 32'h0);
    u_mripi_partner.trig_fall();
    tick(4);
    bus(0, 8'h04, 0);
    chk("trigger flag", rd, 32'h80);
    bus(1, 8'h04, 0);
    $display("t_events done");
  endtask
  task automatic t_priority;
    logic [15:0] vec [4] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B};
    bus(1, 8'h08, 32'hBF);
    bus(1, 8'h04, 32'h3F);
    for (int k = 0; k < 4; k++) begin
      tick(3);
      chk("vector order", irq_vector, vec[k]);
      u_mripi_partner.ack(k);
    end
    tick(3);
    chk("serial vector", irq_vector, 16'h0023);
    bus(0, 8'h04, 0);
    chk("serial kept", rd, 32'h30);
    bus(1, 8'h04, 32'h40);
    tick(3);
    chk("t2 overflow vector", irq_vector, 16'h002B);
    u_mripi_partner.ack(0);
    bus(0, 8'h04, 0);
    chk("t2 flags kept", rd, 32'h40);
    bus(1, 8'h04, 32'h80);
    tick(3);
    chk("t2 trigger vector", irq_vector, 16'h002B);
    bus(1, 8'h04, 0);
    tick(1);
    chk("cancelled", irq_request, 1'b0);
    bus(1, 8'h0C, 32'h20);
    bus(1, 8'h04, 32'h41);
    tick(3);
    chk("high level first", irq_vector, 16'h002B);
    bus(1, 8'h0C, 0);
    tick(3);
    chk("level order", irq_vector, 16'h0003);
    bus(1, 8'h04, 0);
    $display("t_priority done");
  endtask
  task automatic t_idle;
    ext_mem <= 1'b1;
    core_ale <= 1'b1;
    bus(1, 8'h08, 32'h81);
    bus(1, 8'h00, 32'h1);
    tick(2);
    chk("idle halt", cpu_halt, 1'b1);
    chk("idle strobes", {ale, pss, p0f, p2a}, 4'hF);
    chk("idle peripherals", prun, 1'b1);
    bus(0, 8'h08, 0);
    chk("idle keeps enable", rd, 32'h81);
    u_mripi_partner.pulse(0);
    tick(2);
    chk("idle woken", cpu_halt, 1'b0);
    chk("wake vector", irq_vector, 16'h0003);
    bus(0, 8'h00, 0);
    chk("idle bit cleared", rd, 32'h0);
    u_mripi_partner.ack(1);
    tick(1);
    chk("normal strobes", {ale, pss}, 2'h2);
    $display("t_idle done");
  endtask
  task automatic t_powerdown;
    bus(1, 8'h00, 32'h2);
    tick(2);
    chk("pd stop", osc_stop, 1'b1);
    chk("pd pins", {ale, pss, p0f, p2a}, 4'h2);
    chk("pd peripherals", prun, 1'b0);
    ext_mem <= 1'b0;
    tick(1);
    chk("pd internal pins", {ale, pss, p0f, p2a}, 4'h0);
    bus(0, 8'h14, 0);
    chk("pd warning", rd & 32'h83, 32'h82);
    u_mripi_partner.pulse(0);
    u_mripi_partner.hold_reset(10);
    tick(8);
    chk("pd holds", {osc_stop, irq_request, core_reset}, 3'h4);
    u_mripi_partner.hold_reset(40);
    tick(1);
    chk("pd reset exit", {osc_stop, core_reset}, 2'h1);
    tick(10);
    bus(0, 8'h00, 0);
    chk("pd bits cleared", rd, 32'h0);
    $display("t_powerdown done");
  endtask
  task automatic t_idle_reset;
    core_ale <= 1'b0;
    core_pss <= 1'b1;
    bus(1, 8'h08, 32'h81);
    bus(1, 8'h00, 32'h1);
    tick(2);
    chk("idle internal pins", {ale, pss, p0f, p2a}, 4'hC);
    u_mripi_partner.hold_reset(40);
    tick(10);
    chk("idle reset ends", cpu_halt, 1'b0);
    chk("reset strobes", {ale, pss}, 2'h1);
    bus(0, 8'h08, 0);
    chk("enable restarted", rd, 32'h0);
    $display("t_idle_reset done");
  endtask
  // ==========
  // Run and hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tick(8);
    t_regs();
    t_events();
    t_priority();
    t_idle();
    t_powerdown();
    t_idle_reset();
    summarize();
  end
endmodule // mcu_reset_idle_powerdown_irq_test
`default_nettype wire

// file: verification/mripi_checker.sv
// Checker for the reset, low-power and interrupt-entry block.
// Assumes it is bound to the core and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module mripi_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic reset_pin,
  input wire logic core_reset,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic cpu_halt,
  input wire logic state_phase,
  input wire logic osc_stop,
  input wire logic ext_program_mem,
  input wire logic address_latch_strobe,
  input wire logic program_store_strobe,
  input wire logic port0_float,
  input wire logic port2_drive_address
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // Helpers
  logic [5:0] pin_cnt_reg;
  logic idle;
  assign idle = cpu_halt && !osc_stop && !core_reset;
  // Saturates so a long hold cannot wrap back below 24
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pin_cnt_reg <= 6'h00;
    else if (!reset_pin) pin_cnt_reg <= 6'h00;
    else if (pin_cnt_reg != 6'h3F) pin_cnt_reg <= pin_cnt_reg + 6'h01;
  end
  // ==========
  // Properties
  a_reset_filter: assert property ($rose(core_reset) |-> pin_cnt_reg >= 6'h18)
    else $error("core reset after a short pin pulse");
  a_halt_in_reset: assert property (core_reset |-> cpu_halt && !irq_request)
    else $error("core runs while held in reset");
  a_idle_strobes_high: assert property (idle |-> address_latch_strobe && program_store_strobe)
    else $error("strobes not high in idle");
  a_pd_strobes_low: assert property (osc_stop |-> !address_latch_strobe && !program_store_strobe)
    else $error("strobes not low in power-down");
  a_port0_float: assert property (!core_reset |-> port0_float == (cpu_halt && ext_program_mem))
    else $error("port 0 float wrong");
  a_port2_address: assert property (port2_drive_address == (ext_program_mem && !osc_stop))
    else $error("port 2 address drive wrong");
  a_pd_no_request: assert property (osc_stop |-> !irq_request)
    else $error("interrupt request in power-down");
  a_pd_exit_reset: assert property ($fell(osc_stop) |-> core_reset || $past(core_reset))
    else $error("power-down left without reset");
  a_pd_phase_frozen: assert property (osc_stop && $past(osc_stop) |-> $stable(state_phase))
    else $error("phase runs in power-down");
  a_phase_toggles: assert property (!$past(rst) && !osc_stop && !$past(osc_stop) |->
    state_phase != $past(state_phase))
    else $error("phase did not toggle");
  a_idle_wake: assert property (idle && irq_request |=> !idle)
    else $error("pending interrupt did not end idle");
  a_vector_table: assert property (irq_vector inside {16'h0003, 16'h000B, 16'h0013,
    16'h001B, 16'h0023, 16'h002B})
    else $error("vector outside table");
endmodule // mripi_checker

bind mripi_core mripi_checker u_mripi_checker (.clk(clk), .rst(rst), .reset_pin(reset_pin),
  .core_reset(core_reset), .irq_request(irq_request), .irq_vector(irq_vector),
  .cpu_halt(cpu_halt), .state_phase(state_phase), .osc_stop(osc_stop),
  .ext_program_mem(ext_program_mem), .address_latch_strobe(address_latch_strobe),
  .program_store_strobe(program_store_strobe), .port0_float(port0_float),
  .port2_drive_address(port2_drive_address));
`default_nettype wire

// file: verification/mripi_partner.sv
// Reset circuit, interrupt sources and core acknowledge.
// Assumes the bench calls its tasks; all changes follow a rising edge.
`timescale 1ns/10ps
`default_nettype none
module mripi_partner (
  // Clock
  input wire logic clk,
  // Pins toward the block
  output logic reset_pin,
  output logic [6:0] events,
  output logic timer2_trigger_pin,
  output logic irq_ack
);
  initial begin
    reset_pin = 1'b0;
    events = 7'h00;
    timer2_trigger_pin = 1'b1;
    irq_ack = 1'b0;
  end
  // Caller owes 24 cycles plus sync latency for a real reset
  task automatic hold_reset(input int n);
    @(posedge clk) reset_pin <= 1'b1;
    repeat (n) @(posedge clk);
    reset_pin <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge clk) events[i] <= 1'b1;
    @(posedge clk) events <= 7'h00;
  endtask
  // Low long enough to pass the pin filter
  task automatic trig_fall;
    @(posedge clk) timer2_trigger_pin <= 1'b0;
    repeat (6) @(posedge clk);
    timer2_trigger_pin <= 1'b1;
  endtask
  task automatic ack(input int d);
    repeat (d) @(posedge clk);
    @(posedge clk) irq_ack <= 1'b1;
    @(posedge clk) irq_ack <= 1'b0;
  endtask
endmodule // mripi_partner
`default_nettype wire
